// ### common/perf_mon_pkg.sv
/*
 * Package for the channel-1 performance monitor: register offsets, field
 * layouts, reset values, peripheral identifier encoding and event carrier.
 * Assumes a 32-bit plain register port with byte offsets.
 */
package perf_mon_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LATENCY_W = 16;
    localparam int CNT_W = 32;
    localparam int PERIPH_ID_W = 5;

    localparam logic [ADDR_W-1:0] OFS_CH1_READ_MAX_LATENCY = 12'h0824;
    localparam logic [ADDR_W-1:0] OFS_CH1_WRITE_DATA_CYCLES = 12'h0828;
    localparam logic [ADDR_W-1:0] OFS_CH1_WRITE_STALL_CYCLES = 12'h082c;
    localparam logic [ADDR_W-1:0] OFS_CH1_WRITE_MAX_LATENCY = 12'h0830;
    localparam logic [ADDR_W-1:0] OFS_MODULE_VERSION = 12'h0834;
    // stand-in for the monitor control register, which lives outside this block
    localparam logic [ADDR_W-1:0] OFS_MONITOR_CONTROL = 12'h0800;
    localparam int CHANNEL1_COUNTER_RESET_BIT = 1;

    localparam logic [LATENCY_W-1:0] LATENCY_RESET = 16'h0000;
    localparam logic [LATENCY_W-1:0] LATENCY_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [LATENCY_W-1:0] LATENCY_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    localparam int VERSION_LSB = 0;
    localparam int VERSION_W = 12;
    localparam int VARIANT_LSB = 16;
    localparam int VARIANT_W = 4;
    // arbitrary neutral values
    localparam logic [VERSION_W-1:0] VERSION_DEFAULT = 12'h001;
    localparam logic [VARIANT_W-1:0] VARIANT_DEFAULT = 4'h0;

    localparam int NUM_CHANNELS = 8;

    localparam logic [PERIPH_ID_W-1:0] PERIPH_ID_RX_FIRST = 5'h00;
    localparam logic [PERIPH_ID_W-1:0] PERIPH_ID_RX_LAST = 5'h0b;
    localparam logic [PERIPH_ID_W-1:0] PERIPH_ID_TX_FIRST = 5'h0c;
    localparam logic [PERIPH_ID_W-1:0] PERIPH_ID_TX_LAST = 5'h17;

    typedef enum logic [3:0] {
        PERIPH_NONE,
        PERIPH_ANALOG_CONV,
        PERIPH_SYNC_SERIAL,
        PERIPH_ASYNC_SERIAL0,
        PERIPH_ASYNC_SERIAL1,
        PERIPH_ASYNC_SERIAL2,
        PERIPH_ASYNC_SERIAL3,
        PERIPH_TWO_WIRE_MASTER0,
        PERIPH_TWO_WIRE_MASTER1,
        PERIPH_TWO_WIRE_SLAVE0,
        PERIPH_TWO_WIRE_SLAVE1,
        PERIPH_SERIAL_PERIPH0,
        PERIPH_SERIAL_PERIPH1,
        PERIPH_AUDIO_CONV
    } periph_t;

    typedef enum logic [1:0] {
        DIR_NONE,
        DIR_RX,
        DIR_TX
    } dir_t;

    typedef struct packed {
        periph_t periph;
        dir_t dir;
        logic valid;
    } handshake_t;

    // activity of channel 1 as seen on the peripheral-dma bus, one cycle each
    typedef struct packed {
        logic read_wait;
        logic read_start;
        logic write_wait;
        logic write_start;
        logic write_data;
        logic write_stall;
    } ch_event_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage : perf_mon_pkg

// ### logic/latency_tracker.sv
/*
 * One saturating latency tracker: counts wait cycles of the transfer in
 * flight and keeps the largest count seen.
 * Assumes wait and start pulses on the same clock as the tracker.
 */
`timescale 1ns/1ps
`default_nettype none
module latency_tracker
    import perf_mon_pkg::*;
#(
    parameter int WIDTH = LATENCY_W
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic wait_in,
    input wire logic start_in,
    output logic [WIDTH-1:0] max_out
);

    typedef struct packed {
        logic [WIDTH-1:0] cur;
        logic [WIDTH-1:0] max;
    } latency_state_t;

    latency_state_t state_reg;
    latency_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (clear_in) begin
            state_next.cur = '0;
            state_next.max = '0;
        end else begin
            if (wait_in && state_reg.cur != '1) begin
                state_next.cur = state_reg.cur + WIDTH'(1);
            end
            if (start_in) begin
                if (state_reg.cur > state_reg.max) begin
                    state_next.max = state_reg.cur;
                end
                state_next.cur = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign max_out = state_reg.max;

endmodule : latency_tracker
`default_nettype wire

// ### logic/perf_mon_ch1.sv
/*
 * Channel-1 performance monitor of the peripheral DMA unit with version
 * register and peripheral identifier decode.
 * Assumes event strobes from channel-1 bus logic on sys_clk_in and a plain
 * register port with read data one cycle after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module perf_mon_ch1
    import perf_mon_pkg::*;
#(
    parameter logic [VERSION_W-1:0] VERSION_NUM = VERSION_DEFAULT,
    parameter logic [VARIANT_W-1:0] VARIANT_NUM = VARIANT_DEFAULT,
    parameter int CHANNELS = NUM_CHANNELS
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire ch_event_t event_in,
    input wire logic [PERIPH_ID_W-1:0] peripheral_identifier_in,
    output handshake_t handshake_out,
    output logic [3:0] channel_count_out
);

    function automatic handshake_t decode_periph_id(input logic [PERIPH_ID_W-1:0] periph_id);
        handshake_t h;
        h = '{periph: PERIPH_NONE, dir: DIR_NONE, valid: 1'b0};
        if (periph_id <= PERIPH_ID_RX_LAST) begin
            h.dir = DIR_RX;
            h.valid = 1'b1;
            unique case (periph_id)
                5'h00: h.periph = PERIPH_ANALOG_CONV;
                5'h01: h.periph = PERIPH_SYNC_SERIAL;
                5'h02: h.periph = PERIPH_ASYNC_SERIAL0;
                5'h03: h.periph = PERIPH_ASYNC_SERIAL1;
                5'h04: h.periph = PERIPH_ASYNC_SERIAL2;
                5'h05: h.periph = PERIPH_ASYNC_SERIAL3;
                5'h06: h.periph = PERIPH_TWO_WIRE_MASTER0;
                5'h07: h.periph = PERIPH_TWO_WIRE_MASTER1;
                5'h08: h.periph = PERIPH_TWO_WIRE_SLAVE0;
                5'h09: h.periph = PERIPH_TWO_WIRE_SLAVE1;
                5'h0a: h.periph = PERIPH_SERIAL_PERIPH0;
                default: h.periph = PERIPH_SERIAL_PERIPH1;
            endcase
        end else if (periph_id >= PERIPH_ID_TX_FIRST && periph_id <= PERIPH_ID_TX_LAST) begin
            h.dir = DIR_TX;
            h.valid = 1'b1;
            unique case (periph_id)
                5'h0c: h.periph = PERIPH_SYNC_SERIAL;
                5'h0d: h.periph = PERIPH_ASYNC_SERIAL0;
                5'h0e: h.periph = PERIPH_ASYNC_SERIAL1;
                5'h0f: h.periph = PERIPH_ASYNC_SERIAL2;
                5'h10: h.periph = PERIPH_ASYNC_SERIAL3;
                5'h11: h.periph = PERIPH_TWO_WIRE_MASTER0;
                5'h12: h.periph = PERIPH_TWO_WIRE_MASTER1;
                5'h13: h.periph = PERIPH_TWO_WIRE_SLAVE0;
                5'h14: h.periph = PERIPH_TWO_WIRE_SLAVE1;
                5'h15: h.periph = PERIPH_SERIAL_PERIPH0;
                5'h16: h.periph = PERIPH_SERIAL_PERIPH1;
                default: h.periph = PERIPH_AUDIO_CONV;
            endcase
        end
        return h;
    endfunction : decode_periph_id

    typedef struct packed {
        logic [CNT_W-1:0] wdata_cnt;
        logic [CNT_W-1:0] wstall_cnt;
        logic [DATA_W-1:0] rdata;
        handshake_t hs;
        logic [3:0] chan_cnt;
    } mon_state_t;

    mon_state_t state_reg;
    mon_state_t state_next;

    logic latency_clear;
    logic [LATENCY_W-1:0] read_max;
    logic [LATENCY_W-1:0] write_max;

    // a write to any latency register is ignored; only the reset bit clears
    assign latency_clear = wr_in && addr_in == OFS_MONITOR_CONTROL
        && wdata_in[CHANNEL1_COUNTER_RESET_BIT];

    latency_tracker #(
        .WIDTH(LATENCY_W)
    ) u_read_latency (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .clear_in(latency_clear),
        .wait_in(event_in.read_wait),
        .start_in(event_in.read_start),
        .max_out(read_max)
    );

    latency_tracker #(
        .WIDTH(LATENCY_W)
    ) u_write_latency (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .clear_in(latency_clear),
        .wait_in(event_in.write_wait),
        .start_in(event_in.write_start),
        .max_out(write_max)
    );

    always_comb begin
        state_next = state_reg;
        state_next.hs = decode_periph_id(peripheral_identifier_in);
        state_next.chan_cnt = 4'(CHANNELS);
        if (event_in.write_data) begin
            state_next.wdata_cnt = state_reg.wdata_cnt + CNT_ONE;
        end
        if (event_in.write_stall) begin
            state_next.wstall_cnt = state_reg.wstall_cnt + CNT_ONE;
        end
        state_next.rdata = RDATA_ZERO;
        if (rd_in) begin
            unique case (addr_in)
                OFS_CH1_READ_MAX_LATENCY: state_next.rdata = {16'h0000, read_max};
                OFS_CH1_WRITE_DATA_CYCLES: state_next.rdata = state_reg.wdata_cnt;
                OFS_CH1_WRITE_STALL_CYCLES: state_next.rdata = state_reg.wstall_cnt;
                OFS_CH1_WRITE_MAX_LATENCY: state_next.rdata = {16'h0000, write_max};
                OFS_MODULE_VERSION: begin
                    state_next.rdata[VERSION_LSB +: VERSION_W] = VERSION_NUM;
                    state_next.rdata[VARIANT_LSB +: VARIANT_W] = VARIANT_NUM;
                end
                default: state_next.rdata = RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;
    assign handshake_out = state_reg.hs;
    assign channel_count_out = state_reg.chan_cnt;

endmodule : perf_mon_ch1
`default_nettype wire

// ### sim/perf_mon_ch1_checker.sv
/* assertions on the ports of perf_mon_ch1.
   assumes it is bound into the design top; reset is synchronous, active low. */
`timescale 1ns/1ps
`default_nettype none
module perf_mon_ch1_checker
    import perf_mon_pkg::*;
#(
    parameter logic [VERSION_W-1:0] VERSION_NUM = VERSION_DEFAULT,
    parameter logic [VARIANT_W-1:0] VARIANT_NUM = VARIANT_DEFAULT
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire ch_event_t event_in,
    input wire logic [PERIPH_ID_W-1:0] peripheral_identifier_in,
    input wire handshake_t handshake_out,
    input wire logic [3:0] channel_count_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    ver_value_a: assert property (rd_in && addr_in == OFS_MODULE_VERSION |=> rdata_out[11:0] == VERSION_NUM)
        else $error("version field wrong");
    ver_variant_a: assert property (rd_in && addr_in == OFS_MODULE_VERSION |=>
        rdata_out[31:12] == {12'h000, VARIANT_NUM, 4'h0}) else $error("variant bits wrong");
    rlat_upper_a: assert property (rd_in && addr_in == OFS_CH1_READ_MAX_LATENCY |=> rdata_out[31:16] == 16'h0000)
        else $error("read latency upper bits set");
    wlat_upper_a: assert property (rd_in && addr_in == OFS_CH1_WRITE_MAX_LATENCY |=> rdata_out[31:16] == 16'h0000)
        else $error("write latency upper bits set");
    chan_count_a: assert property ($past(nrst_in) |-> channel_count_out == 4'h8)
        else $error("channel count wrong");
    rx_decode_a: assert property (peripheral_identifier_in <= PERIPH_ID_RX_LAST |=> handshake_out.valid &&
        handshake_out.dir == DIR_RX && handshake_out.periph == periph_t'($past(peripheral_identifier_in) + 1))
        else $error("receive decode wrong");
    tx_decode_a: assert property (peripheral_identifier_in inside {[PERIPH_ID_TX_FIRST:PERIPH_ID_TX_LAST]} |=>
        handshake_out.valid && handshake_out.dir == DIR_TX
        && handshake_out.periph == periph_t'($past(peripheral_identifier_in) - 10))
        else $error("transmit decode wrong");
    undef_decode_a: assert property (peripheral_identifier_in > PERIPH_ID_TX_LAST |=> !handshake_out.valid &&
        handshake_out.dir == DIR_NONE && handshake_out.periph == PERIPH_NONE) else $error("undefined id decoded");
    latency_clear_a: assert property (wr_in && addr_in == OFS_MONITOR_CONTROL && wdata_in[1] ##1
        !event_in.read_start ##1 rd_in && addr_in == OFS_CH1_READ_MAX_LATENCY |=> rdata_out == RDATA_ZERO)
        else $error("latency not cleared");
endmodule : perf_mon_ch1_checker
`default_nettype wire

// ### sim/event_source.sv
/* partner model: channel-1 bus activity seen by the monitor.
   assumes the bench calls one task at a time. */
`timescale 1ns/1ps
`default_nettype none
module event_source
    import perf_mon_pkg::*;
(
    input wire logic clk_in,
    output ch_event_t ev_out
);
    initial ev_out = '0;
    // n wait cycles then the start pulse; wr picks the write side
    task automatic xfer(input logic wr, input int n);
        repeat (n) begin
            @(posedge clk_in);
            ev_out <= wr ? 6'h08 : 6'h20;
        end
        @(posedge clk_in);
        ev_out <= wr ? 6'h04 : 6'h10;
        @(posedge clk_in);
        ev_out <= '0;
    endtask : xfer
    task automatic pulses(input ch_event_t p, input int n);
        repeat (n) begin
            @(posedge clk_in);
            ev_out <= p;
        end
        @(posedge clk_in);
        ev_out <= '0;
    endtask : pulses
endmodule : event_source
`default_nettype wire

// ### sim/test_perf_mon_ch1.sv
/* self-checking bench for perf_mon_ch1.
   assumes event_source drives all channel-1 activity. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_perf_mon_ch1
    import perf_mon_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [PERIPH_ID_W-1:0] periph_id = '0;
    logic [DATA_W-1:0] rdata;
    ch_event_t ev;
    handshake_t hs;
    logic [3:0] chans;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    event_source i_src (.clk_in(clk), .ev_out(ev));
    perf_mon_ch1 i_dut (.sys_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .event_in(ev), .peripheral_identifier_in(periph_id),
        .handshake_out(hs), .channel_count_out(chans));
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", ex, rdata)
    endtask : rd_chk
    task automatic t_reset_values;
        rd_chk(OFS_CH1_READ_MAX_LATENCY, CNT_RESET);
        rd_chk(OFS_CH1_WRITE_DATA_CYCLES, CNT_RESET);
        rd_chk(OFS_CH1_WRITE_STALL_CYCLES, CNT_RESET);
        rd_chk(OFS_CH1_WRITE_MAX_LATENCY, CNT_RESET);
        rd_chk(OFS_MODULE_VERSION, {12'h000, VARIANT_DEFAULT, 4'h0, VERSION_DEFAULT});
        `CHK("channels", 4'h8, chans)
    endtask : t_reset_values
    task automatic t_counters;
        i_src.pulses(6'h02, 5);
        i_src.pulses(6'h03, 3);
        wr_reg(OFS_CH1_WRITE_DATA_CYCLES, 32'hffff_ffff);
        rd_chk(OFS_CH1_WRITE_DATA_CYCLES, 32'h0000_0008);
        rd_chk(OFS_CH1_WRITE_STALL_CYCLES, 32'h0000_0003);
    endtask : t_counters
    task automatic t_latency;
        i_src.xfer(1'b0, 4);
        i_src.xfer(1'b0, 2);
        i_src.xfer(1'b1, 7);
        wr_reg(OFS_CH1_READ_MAX_LATENCY, 32'h0000_0000);
        rd_chk(OFS_CH1_READ_MAX_LATENCY, 32'h0000_0004);
        rd_chk(OFS_CH1_WRITE_MAX_LATENCY, 32'h0000_0007);
        // bit 0 belongs to the other channel and must leave ours alone
        wr_reg(OFS_MONITOR_CONTROL, 32'h0000_0001);
        rd_chk(OFS_CH1_READ_MAX_LATENCY, 32'h0000_0004);
        wr_reg(OFS_MONITOR_CONTROL, 32'h0000_0002);
        rd_chk(OFS_CH1_READ_MAX_LATENCY, CNT_RESET);
        rd_chk(OFS_CH1_WRITE_MAX_LATENCY, CNT_RESET);
    endtask : t_latency
    task automatic t_saturate;
        // both sides wait past full scale together to keep the run short
        i_src.pulses(6'h28, 65540);
        i_src.pulses(6'h14, 1);
        rd_chk(OFS_CH1_READ_MAX_LATENCY, {16'h0000, LATENCY_MAX});
        rd_chk(OFS_CH1_WRITE_MAX_LATENCY, {16'h0000, LATENCY_MAX});
    endtask : t_saturate
    task automatic t_mid_reset;
        // counters and saturated latencies must all return to zero
        i_src.pulses(6'h03, 2);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
    endtask : t_mid_reset
    task automatic t_decode;
        for (int i = 0; i < 25; i++) begin
            @(posedge clk);
            periph_id <= PERIPH_ID_W'(i);
            @(posedge clk);
            #1;
            `CHK("dir", i < 12 ? DIR_RX : i < 24 ? DIR_TX : DIR_NONE, hs.dir)
            `CHK("periph", i < 12 ? periph_t'(i + 1) : i < 24 ? periph_t'(i - 10) : PERIPH_NONE, hs.periph)
            `CHK("valid", i < 24, hs.valid)
        end
    endtask : t_decode
    task automatic summarize;
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_counters();
        t_latency();
        t_saturate();
        t_mid_reset();
        t_decode();
        summarize();
    end
endmodule : test_perf_mon_ch1
bind perf_mon_ch1 perf_mon_ch1_checker #(.VERSION_NUM(VERSION_NUM), .VARIANT_NUM(VARIANT_NUM)) i_chk (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .event_in(event_in), .peripheral_identifier_in(peripheral_identifier_in),
    .handshake_out(handshake_out), .channel_count_out(channel_count_out));
`default_nettype wire
